// file: core/memory_region_decoder_pkg.sv
// constants, types and helpers shared by the memory region decoder
package memory_region_decoder_pkg;

    // ----------------------------------------------------------------
    // address geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned OFFSET_W    = 26;   // byte address per region
    localparam int unsigned WINDOW_W    = 6;    // addr[31:26], 64 MB steps
    localparam int unsigned STATIC_N    = 6;
    localparam int unsigned SYNC_OK_N   = 4;    // regions 0..3 may be sync
    localparam int unsigned SDRAM_N     = 4;
    localparam int unsigned CARD_N      = 2;
    localparam int unsigned REGWIN_N    = 3;
    localparam int unsigned TYPE_W      = 3;
    localparam int unsigned DIV_W       = 4;

    localparam logic [31:0] STATIC_BASE        = 32'h0000_0000;
    localparam logic [31:0] REGION_SPAN        = 32'h0400_0000;
    localparam logic [31:0] STATIC_LAST_BASE   = 32'h1400_0000;
    localparam logic [31:0] RESERVED_LOW_BASE  = 32'h1800_0000;
    localparam logic [31:0] CARD0_BASE         = 32'h2000_0000;
    localparam logic [31:0] CARD1_BASE         = 32'h3000_0000;
    localparam logic [31:0] PERIPH_BASE        = 32'h4000_0000;
    localparam logic [31:0] DISPLAY_BASE       = 32'h4400_0000;
    localparam logic [31:0] MEMCTL_BASE        = 32'h4800_0000;
    localparam logic [31:0] RESERVED_HIGH_BASE = 32'h4C00_0000;
    localparam logic [31:0] RESERVED_HIGH_LAST = 32'h6000_0000;
    localparam logic [31:0] SDRAM_BASE_DEFAULT = 32'h8000_0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned MCLK_FREQ_KHZ      = 20000;
    localparam int unsigned SDRAM_MAX_FREQ_KHZ = 100000;
    // least divide that keeps the memory clock at or below its ceiling
    localparam int unsigned SDRAM_MIN_DIV_RAW  =
        (MCLK_FREQ_KHZ + SDRAM_MAX_FREQ_KHZ - 1) / SDRAM_MAX_FREQ_KHZ;
    localparam logic [DIV_W-1:0] SDRAM_MIN_DIV =
        DIV_W'((SDRAM_MIN_DIV_RAW < 1) ? 1 : SDRAM_MIN_DIV_RAW);
    localparam logic [DIV_W-1:0] DIV_RESET     = 4'h1;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_STATIC, KIND_CARD, KIND_REGS, KIND_SDRAM, KIND_RESERVED
    } region_kind_t;

    typedef enum logic [TYPE_W-1:0] {
        MEM_ASYNC_ROM, MEM_PAGE_ROM, MEM_ASYNC_FLASH, MEM_SRAM,
        MEM_VARIABLE_LATENCY_IO, MEM_SYNC_FLASH, MEM_SYNCHRONOUS_MASK_ROM
    } mem_type_t;

    // true for memory types that need the synchronous static clock
    function automatic logic is_sync_type(input logic [TYPE_W-1:0] t);
        is_sync_type = (t == MEM_SYNC_FLASH) ||
                       (t == MEM_SYNCHRONOUS_MASK_ROM);
    endfunction : is_sync_type

    // effective divide, never faster than the memory clock ceiling
    function automatic logic [DIV_W-1:0] safe_div(input logic [DIV_W-1:0] d);
        safe_div = (d < SDRAM_MIN_DIV) ? SDRAM_MIN_DIV : d;
    endfunction : safe_div

endpackage : memory_region_decoder_pkg

// file: core/region_lookup.sv
// combinational address to region lookup
`timescale 1ns/1ps
`default_nettype none
module region_lookup
    import memory_region_decoder_pkg::*;
#(
    parameter logic [31:0] SDRAM_BASE = SDRAM_BASE_DEFAULT
) (
    input  wire logic [ADDR_W-1:0]   addr,
    output region_kind_t             kind,
    output logic [2:0]               index,
    output logic [OFFSET_W-1:0]      offset
);

    // window numbers of the fixed map, one per 64 MB
    localparam logic [WINDOW_W-1:0] WIN_STATIC_LAST =
        STATIC_LAST_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_RES_LOW   = RESERVED_LOW_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_CARD0     = CARD0_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_CARD1     = CARD1_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_PERIPH    = PERIPH_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_DISPLAY   = DISPLAY_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_MEMCTL    = MEMCTL_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_RES_HIGH  = RESERVED_HIGH_BASE[31:26];
    localparam logic [WINDOW_W-1:0] WIN_RES_LAST  = RESERVED_HIGH_LAST[31:26];

    logic [WINDOW_W-1:0] win;

    assign win    = addr[31:26];
    assign offset = addr[OFFSET_W-1:0];

    // priority walk over the map; anything unmatched reaches no device
    always_comb begin
        kind  = KIND_RESERVED;
        index = 3'h0;
        if (win <= WIN_STATIC_LAST) begin
            kind  = KIND_STATIC;
            index = win[2:0];
        end else if (win >= WIN_RES_LOW && win < WIN_CARD0) begin
            kind = KIND_RESERVED;
        end else if (win >= WIN_CARD0 && win < WIN_CARD1) begin
            kind = KIND_CARD;
        end else if (win >= WIN_CARD1 && win < WIN_PERIPH) begin
            kind  = KIND_CARD;
            index = 3'h1;
        end else if (win == WIN_PERIPH || win == WIN_DISPLAY ||
                     win == WIN_MEMCTL) begin
            kind  = KIND_REGS;
            index = 3'(win - WIN_PERIPH);
        end else if (win >= WIN_RES_HIGH && win <= WIN_RES_LAST) begin
            kind = KIND_RESERVED;
        end else if (addr[31:28] == SDRAM_BASE[31:28]) begin
            kind  = KIND_SDRAM;
            index = {1'b0, addr[27:26]};
        end
    end

endmodule : region_lookup
`default_nettype wire

// file: core/memory_region_decoder.sv
// external memory bus region decoder with partition pair settings
//
// What this block does
// RULE1: six 64 MB static regions from zero, region n at n times 64 MB.
// RULE2: 256 MB at 0x2000_0000 goes to card slot 0, 0x3000_0000 slot 1.
// RULE3: peripheral, display and controller register windows, 64 MB each.
// RULE4: 0x1800_0000-0x1FFF_FFFF and 0x4C00_0000-0x63FF_FFFF reach no device.
// RULE5: SDRAM clock never runs above 100 MHz.
// RULE6: four SDRAM partitions, each 16-bit or 32-bit wide.
// RULE7: each SDRAM partition owns a full 64 MB window.
// RULE8: software keeps both partitions of a pair identical.
// RULE9: each pair has its own clock rate and data width.
// RULE10: memory type per region comes from software-written settings.
// RULE11: static region gets 26-bit byte offset and only its own select.
// RULE12: only static regions 0..3 may run synchronous memory types.
// RULE13: at most one select per address, none for reserved space.
`timescale 1ns/1ps
`default_nettype none
module memory_region_decoder
    import memory_region_decoder_pkg::*;
#(
    parameter logic [31:0] SDRAM_BASE = SDRAM_BASE_DEFAULT
) (
    input  wire logic                      mclk,
    input  wire logic                      srst,
    // request from the internal bus master
    input  wire logic                      reqValid,
    input  wire logic [ADDR_W-1:0]         reqAddr,
    // settings held by the controller's configuration registers
    input  wire logic [STATIC_N*TYPE_W-1:0] staticTypeCfg,
    input  wire logic [STATIC_N-1:0]       staticWideCfg,
    input  wire logic [1:0]                pairWideCfg,
    input  wire logic [DIV_W-1:0]          pairDivCfg0,
    input  wire logic [DIV_W-1:0]          pairDivCfg1,
    // decoded answer, one cycle after the request
    output logic                           respValid,
    output logic [STATIC_N-1:0]            staticRegionSelect_n,
    output logic [CARD_N-1:0]              cardSelect,
    output logic [REGWIN_N-1:0]            regWindowSelect,
    output logic [SDRAM_N-1:0]             sdramSelect,
    output logic                           reservedHit,
    output logic [OFFSET_W-1:0]            regionOffset,
    output logic [TYPE_W-1:0]              memType,
    output logic                           busWide,
    output logic                           syncTypeRefused,
    // memory clock enables, one per partition pair
    output logic [1:0]                     pairTick
);

    // ----------------------------------------------------------------
    // address lookup
    // ----------------------------------------------------------------
    region_kind_t        kind;
    logic [2:0]          index;
    logic [OFFSET_W-1:0] offset;

    region_lookup #(
        .SDRAM_BASE (SDRAM_BASE)
    ) u_lookup (
        .addr   (reqAddr),
        .kind   (kind),
        .index  (index),
        .offset (offset)
    );

    // ----------------------------------------------------------------
    // select and attribute decode
    // ----------------------------------------------------------------
    logic                  respValid_nxt;
    logic [STATIC_N-1:0]   staticSel_nxt;
    logic [CARD_N-1:0]     cardSel_nxt;
    logic [REGWIN_N-1:0]   regSel_nxt;
    logic [SDRAM_N-1:0]    sdramSel_nxt;
    logic                  reserved_nxt;
    logic [OFFSET_W-1:0]   offset_nxt;
    logic [TYPE_W-1:0]     type_nxt;
    logic                  wide_nxt;
    logic                  refused_nxt;
    logic [TYPE_W-1:0]     cfgType;

    // configured type of the addressed static region
    always_comb begin
        cfgType = staticTypeCfg[index*TYPE_W +: TYPE_W];
    end

    // one-hot selects; every select stays idle without a request
    always_comb begin
        respValid_nxt = reqValid;
        staticSel_nxt = '0;
        cardSel_nxt   = '0;
        regSel_nxt    = '0;
        sdramSel_nxt  = '0;
        reserved_nxt  = 1'b0;
        offset_nxt    = '0;
        type_nxt      = MEM_ASYNC_ROM;
        wide_nxt      = 1'b0;
        refused_nxt   = 1'b0;
        if (reqValid) begin
            // RULE13 single select
            case (kind)
                KIND_STATIC: begin
                    // RULE1 static region map
                    staticSel_nxt[index] = 1'b1;
                    // RULE11 byte offset
                    offset_nxt = offset;
                    wide_nxt   = staticWideCfg[index];
                    // RULE10 software type
                    type_nxt   = cfgType;
                    // RULE12 sync types demoted
                    if (index >= 3'(SYNC_OK_N) && is_sync_type(cfgType)) begin
                        type_nxt    = MEM_ASYNC_ROM;
                        refused_nxt = 1'b1;
                    end
                end
                KIND_CARD: begin
                    // RULE2 card slot windows
                    cardSel_nxt[index[0]] = 1'b1;
                    offset_nxt = offset;
                end
                KIND_REGS: begin
                    // RULE3 register windows
                    regSel_nxt[index[1:0]] = 1'b1;
                    offset_nxt = offset;
                end
                KIND_SDRAM: begin
                    // RULE7 64 MB per partition
                    sdramSel_nxt[index[1:0]] = 1'b1;
                    offset_nxt = offset;
                    // RULE6 partition width
                    // RULE8 pair shares one setting
                    wide_nxt = pairWideCfg[index[1]];
                end
                KIND_RESERVED: begin
                    // RULE4 reserved space
                    reserved_nxt = 1'b1;
                end
                default: begin
                    reserved_nxt = 1'b1;
                end
            endcase
        end
    end

    // answer registers, updated every cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            respValid            <= 1'b0;
            staticRegionSelect_n <= '1;
            cardSelect           <= '0;
            regWindowSelect      <= '0;
            sdramSelect          <= '0;
            reservedHit          <= 1'b0;
            regionOffset         <= '0;
            memType              <= MEM_ASYNC_ROM;
            busWide              <= 1'b0;
            syncTypeRefused      <= 1'b0;
        end else begin
            respValid            <= respValid_nxt;
            staticRegionSelect_n <= ~staticSel_nxt;
            cardSelect           <= cardSel_nxt;
            regWindowSelect      <= regSel_nxt;
            sdramSelect          <= sdramSel_nxt;
            reservedHit          <= reserved_nxt;
            regionOffset         <= offset_nxt;
            memType              <= type_nxt;
            busWide              <= wide_nxt;
            syncTypeRefused      <= refused_nxt;
        end
    end

    // ----------------------------------------------------------------
    // memory clock enables per partition pair
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] divCnt_r   [2];
    logic [DIV_W-1:0] divCnt_nxt [2];
    logic [1:0]       tick_r;
    logic [1:0]       tick_nxt;
    logic [DIV_W-1:0] divLimit   [2];

    // RULE5 clamp to ceiling
    always_comb begin
        divLimit[0] = safe_div(pairDivCfg0);
        divLimit[1] = safe_div(pairDivCfg1);
    end

    // RULE9 independent pair rates
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            if (divCnt_r[p] + 4'h1 >= divLimit[p]) begin
                divCnt_nxt[p] = 4'h0;
                tick_nxt[p]   = 1'b1;
            end else begin
                divCnt_nxt[p] = divCnt_r[p] + 4'h1;
                tick_nxt[p]   = 1'b0;
            end
        end
    end

    // divider state, a tick every divLimit cycles
    always_ff @(posedge mclk) begin
        if (srst) begin
            divCnt_r[0] <= 4'h0;
            divCnt_r[1] <= 4'h0;
            tick_r      <= 2'h0;
        end else begin
            divCnt_r[0] <= divCnt_nxt[0];
            divCnt_r[1] <= divCnt_nxt[1];
            tick_r      <= tick_nxt;
        end
    end

    assign pairTick = tick_r;

endmodule : memory_region_decoder
`default_nettype wire

// file: verification/memory_region_decoder_sva.sv
// assertion checker for the memory region decoder ports
`timescale 1ns/1ps
`default_nettype none
module memory_region_decoder_sva
    import memory_region_decoder_pkg::*;
#(
    parameter logic [31:0] SDRAM_BASE = SDRAM_BASE_DEFAULT
) (
    input wire logic                        mclk,
    input wire logic                        srst,
    input wire logic                        reqValid,
    input wire logic [ADDR_W-1:0]           reqAddr,
    input wire logic [STATIC_N*TYPE_W-1:0]  staticTypeCfg,
    input wire logic [DIV_W-1:0]            pairDivCfg0,
    input wire logic [DIV_W-1:0]            pairDivCfg1,
    input wire logic                        respValid,
    input wire logic [STATIC_N-1:0]         staticRegionSelect_n,
    input wire logic [CARD_N-1:0]           cardSelect,
    input wire logic [REGWIN_N-1:0]         regWindowSelect,
    input wire logic [SDRAM_N-1:0]          sdramSelect,
    input wire logic                        reservedHit,
    input wire logic [OFFSET_W-1:0]         regionOffset,
    input wire logic [TYPE_W-1:0]           memType,
    input wire logic                        syncTypeRefused,
    input wire logic [1:0]                  pairTick
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic [1:0][DIV_W:0] gapCnt_r;
    logic [1:0][DIV_W:0] gapCnt_nxt;
    logic [1:0]          seen_r;
    logic [1:0]          seen_nxt;

    // cycles since the last tick of each pair
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            gapCnt_nxt[p] = pairTick[p] ? 5'h01 : gapCnt_r[p] + 5'h01;
        end
        seen_nxt = seen_r | pairTick;
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            gapCnt_r <= '0;
            seen_r   <= '0;
        end else begin
            gapCnt_r <= gapCnt_nxt;
            seen_r   <= seen_nxt;
        end
    end

    sequence s_static_req;
        reqValid && reqAddr[31:26] < 6'h06;
    endsequence
    sequence s_sync_high;
        reqValid && reqAddr[31:27] == 5'h02 &&
        (reqAddr[26] ? staticTypeCfg[17:15] : staticTypeCfg[14:12]) > 3'h4;
    endsequence

    a_resp_pulse: assert property (reqValid ##1 !reqValid |->
        respValid ##1 !respValid) else $error("answer not one cycle");
    a_idle_quiet: assert property (!reqValid |=> !respValid &&
        &staticRegionSelect_n && !reservedHit &&
        ({cardSelect, regWindowSelect, sdramSelect} == 9'h000))
        else $error("select without request");
    a_static_select: assert property (s_static_req |=>
        staticRegionSelect_n == ~(6'h01 << $past(reqAddr[28:26])))
        else $error("wrong static select");
    a_card_route: assert property (reqValid &&
        reqAddr[31:29] == 3'h1 |=> cardSelect == (2'h1 << $past(reqAddr[28])))
        else $error("wrong card slot");
    a_regwin_route: assert property (reqValid && reqAddr[31:28] == 4'h4 &&
        reqAddr[27:26] != 2'h3 |=>
        regWindowSelect == (3'h1 << $past(reqAddr[27:26])))
        else $error("wrong register window");
    a_reserved_low: assert property (reqValid &&
        reqAddr[31:27] == 5'h03 |=> reservedHit && &staticRegionSelect_n)
        else $error("low reserved space decoded");
    a_sdram_route: assert property (reqValid &&
        reqAddr[31:28] == SDRAM_BASE[31:28] |=>
        sdramSelect == (4'h1 << $past(reqAddr[27:26])))
        else $error("wrong sdram partition");
    a_one_select: assert property (respValid |-> $countones({
        ~staticRegionSelect_n, cardSelect, regWindowSelect, sdramSelect,
        reservedHit}) == 1) else $error("select count not one");
    a_offset_pass: assert property (respValid && !reservedHit |->
        regionOffset == $past(reqAddr[25:0])) else $error("bad offset");
    a_sync_refused: assert property (s_sync_high |=>
        syncTypeRefused && memType == 3'h0) else $error("sync type kept");

    for (genvar p = 0; p < 2; p++) begin : g_tick
        wire logic [DIV_W-1:0] div = p ? pairDivCfg1 : pairDivCfg0;
        a_tick_period: assert property (@(posedge mclk) disable iff (srst)
            pairTick[p] && seen_r[p] |->
            gapCnt_r[p] == ((div == 4'h0) ? 5'h01 : {1'b0, div}))
            else $error("tick period wrong");
    end
endmodule : memory_region_decoder_sva

bind memory_region_decoder memory_region_decoder_sva #(
    .SDRAM_BASE(SDRAM_BASE)
) u_sva (.*);
`default_nettype wire

// file: verification/memory_partner.sv
// behavioural model of the far-side memories and card slots
`timescale 1ns/1ps
`default_nettype none
module memory_partner (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [5:0] staticRegionSelect_n,
    input  wire logic [1:0] cardSelect,
    input  wire logic [3:0] sdramSelect,
    output logic [15:0]     accessCount_r
);
    logic [15:0] accessCount_nxt;

    always_comb begin
        accessCount_nxt = accessCount_r + 16'($countones(
            {~staticRegionSelect_n, cardSelect, sdramSelect}));
    end
    always_ff @(posedge mclk) begin
        if (srst) accessCount_r <= 16'h0000;
        else accessCount_r <= accessCount_nxt;
    end
endmodule : memory_partner
`default_nettype wire

// file: verification/memory_region_decoder_tb_top.sv
// self-checking bench for the memory region decoder
`timescale 1ns/1ps
`default_nettype none
module memory_region_decoder_tb_top;
    import memory_region_decoder_pkg::*;
    logic        mclk, srst, reqValid, respValid, reservedHit;
    logic        busWide, syncTypeRefused;
    logic [31:0] reqAddr, lfsr;
    logic [17:0] staticTypeCfg;
    logic [5:0]  staticWideCfg, staticRegionSelect_n;
    logic [1:0]  pairWideCfg, cardSelect, pairTick;
    logic [3:0]  pairDivCfg0, pairDivCfg1, sdramSelect;
    logic [2:0]  regWindowSelect, memType;
    logic [25:0] regionOffset;
    logic [15:0] accessCount_r;
    logic [47:0] expQ [$];
    int          err_total, comparisons, cycles, expAcc, tick0, tick1;
    wire logic [47:0] outVec = {respValid, staticRegionSelect_n, cardSelect,
        regWindowSelect, sdramSelect, reservedHit, regionOffset, memType,
        busWide, syncTypeRefused};

    memory_region_decoder i_dut (.*);
    memory_partner i_partner (.*);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    // reference decode of one request
    function automatic logic [47:0] model(input logic v, input logic [31:0] a);
        logic [5:0]  sn;
        logic [1:0]  cd;
        logic [2:0]  rw, mt;
        logic [3:0]  sd;
        logic [25:0] of;
        logic        rs, bw, sr;
        int          w;
        sn = 6'h3F; cd = 2'h0; rw = 3'h0; sd = 4'h0; of = 26'h0;
        mt = 3'h0; rs = 1'b0; bw = 1'b0; sr = 1'b0; w = a[31:26];
        if (v) begin
            of = a[25:0];
            if (w < 6) begin
                sn[w] = 1'b0;
                mt = staticTypeCfg[3*w+:3];
                bw = staticWideCfg[w];
                if (w > 3 && mt > 3'h4) begin
                    sr = 1'b1;
                    mt = 3'h0;
                end
            end else if (w >= 8 && w < 16) cd[w/4-2] = 1'b1;
            else if (w >= 16 && w < 19) rw[w-16] = 1'b1;
            else if (a[31:28] == 4'h8) begin
                sd[a[27:26]] = 1'b1;
                bw = pairWideCfg[a[27]];
            end else begin
                rs = 1'b1;
                of = 26'h0;
            end
        end
        return {v, sn, cd, rw, sd, rs, of, mt, bw, sr};
    endfunction : model

    task automatic check(input string nm, input logic [47:0] seen,
                         input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic step(input logic v, input logic [31:0] a);
        logic [47:0] e;
        @(negedge mclk);
        if (expQ.size() > 0) check("decode", outVec, expQ.pop_front());
        e = model(v, a);
        if (|{~e[46:41], e[40:39], e[35:32]}) expAcc++;
        reqValid = v;
        reqAddr = a;
        expQ.push_back(e);
    endtask : step

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop;
        end
    end

    initial begin
        srst = 1'b1; reqValid = 1'b0; reqAddr = 32'h0000_0000;
        staticTypeCfg = 18'h00000; staticWideCfg = 6'h00; pairWideCfg = 2'h0;
        pairDivCfg0 = 4'h0; pairDivCfg1 = 4'h5; lfsr = 32'h0000_0020;
        // count rising edges so a time-zero clock event cannot shorten reset
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        for (int r = 0; r < 7; r++) begin
            step(1'b0, lfsr);
            for (int n = 0; n < 6; n++) staticTypeCfg[3*n+:3] = 3'((n + r) % 7);
            staticWideCfg = lfsr[5:0];
            pairWideCfg = 2'(r);
            for (int w = 0; w < 64; w++) begin
                lfsr = next_rand(lfsr);
                step(1'b1, {6'(w), lfsr[25:0]});
            end
        end
        for (int i = 0; i < 300; i++) begin
            lfsr = next_rand(lfsr);
            step(lfsr[3:0] != 4'h0, lfsr);
        end
        step(1'b0, 32'h0000_0000);
        step(1'b0, 32'h0000_0000);
        check("accesses", 48'(accessCount_r), 48'(expAcc));
        step(1'b1, 32'h0800_0010);
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        check("reset", outVec, {1'b0, 6'h3F, 41'h0});
        expQ.delete();
        srst = 1'b0;
        step(1'b1, 32'h0800_0010);
        step(1'b0, 32'h0000_0000);
        step(1'b0, 32'h0000_0000);
        tick0 = 0;
        tick1 = 0;
        repeat (60) begin
            @(negedge mclk);
            tick0 += pairTick[0];
            tick1 += pairTick[1];
        end
        check("tick0", 48'(tick0), 48'h3C);
        check("tick1", 48'(tick1), 48'h0C);
        report_and_stop;
    end
endmodule : memory_region_decoder_tb_top
`default_nettype wire
